// ==== sim/sadc_control_properties.sv ====
// Port checks of the converter control
`timescale 1ns/1ns
`include "sadc_consts.vh"
module sadc_control_properties (
   // Clock and reset
   input wire        clk_in,
   input wire        sys_rst_in,
   // APB
   input wire        psel_in,
   input wire        penable_in,
   input wire        pwrite_in,
   input wire [11:0] paddr_in,
   input wire [31:0] pwdata_in,
   input wire [31:0] prdata_out,
   input wire        pslverr_out,
   // Analog side
   input wire [11:0] dac_code_out,
   input wire [3:0]  input_channel_select_out,
   input wire        analog_enable_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // ==========
   // Helpers
   logic [9:0] cnt;
   logic [9:0] dv;
   logic [3:0] ch_w;
   logic       aborted;
   wire        acc = psel_in && penable_in;
   wire        wr_mode = acc && pwrite_in && paddr_in == `SADC_MODE_ADDR;
   wire        mapped = paddr_in == `SADC_MODE_ADDR || paddr_in == `SADC_RES_HIGH_ADDR ||
                        paddr_in == `SADC_RES_LOW_ADDR || paddr_in == `SADC_IRQ_STAT_ADDR ||
                        paddr_in == `SADC_IRQ_MASK_ADDR;
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cnt <= 10'h000;
         dv <= 10'h001;
         ch_w <= 4'h0;
         aborted <= 1'b0;
      end else begin
         cnt <= analog_enable_out ? cnt + 10'h001 : 10'h000;
         if (wr_mode) begin
            dv <= 10'h001 << pwdata_in[5:4];
            ch_w <= pwdata_in[3:0];
            aborted <= !pwdata_in[7];
         end
      end
   end
   // ==========
   // Assertions
   unmapped_err_a: assert property (acc && !mapped |-> pslverr_out)
      else $error("no error on unmapped access");
   mapped_ok_a: assert property (acc && mapped |-> !pslverr_out)
      else $error("error on mapped access");
   unmapped_read_a: assert property (acc && !pwrite_in && !mapped |-> prdata_out == 32'h0)
      else $error("unmapped read not zero");
   chan_follow_a: assert property (wr_mode |=> ##[0:1] input_channel_select_out == ch_w)
      else $error("channel output does not follow write");
   bad_chan_a: assert property (analog_enable_out |-> input_channel_select_out <= 4'ha)
      else $error("analog path on unavailable channel");
   abort_stop_a: assert property (wr_mode && !pwdata_in[7] && analog_enable_out
      |-> ##[1:4] !analog_enable_out)
      else $error("stop did not end conversion");
   first_trial_a: assert property ($rose(analog_enable_out)
      |-> ##[0:3] dac_code_out == 12'h800)
      else $error("first trial not mid-scale");
   conv_length_a: assert property ($fell(analog_enable_out) && !aborted
      |-> cnt >= 57 * dv && cnt <= 58 * dv + dv + 10'd8)
      else $error("conversion length wrong");
endmodule
bind sadc_control sadc_control_properties chk_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
   .dac_code_out(dac_code_out), .input_channel_select_out(input_channel_select_out),
   .analog_enable_out(analog_enable_out));

// ==== sim/sadc_fe_model.sv ====
// Analog front end model: input mux, resistor-string DAC and comparator
`timescale 1ns/1ns
module sadc_fe_model (
   // Clock
   input  wire          clk_in,
   // From the converter
   input  wire [11:0]   dac_code_in,
   input  wire [3:0]    chan_in,
   input  wire          enable_in,
   // Levels in code units, channel 0 lowest
   input  wire [131:0]  levels_in,
   // To the converter
   output wire          comparator_out
);
   // ==========
   // Comparator
   logic                idle_reg = 1'b0;
   logic                above_w;
   // A disconnected comparator wanders; a toggle stands in for it
   always @(posedge clk_in) begin
      idle_reg <= ~idle_reg;
   end
   // Analog path has no register: a clocked model would add a cycle of lag
   // Level sits half a step above its code, so no tie at equal codes
   assign above_w = {levels_in[chan_in*12 +: 12], 1'b1} > {dac_code_in, 1'b0};
   assign comparator_out = (enable_in && chan_in <= 4'ha) ? above_w : idle_reg;
endmodule

// ==== sim/test_sar_adc_control.sv ====
// Self-checking bench for the converter control
`timescale 1ns/1ns
`include "sadc_consts.vh"
module test_sar_adc_control;
   // ==========
   // Signals
   logic          clk_in = 1'b0;
   logic          sys_rst_in = 1'b1;
   logic          psel_in = 1'b0;
   logic          penable_in = 1'b0;
   logic          pwrite_in = 1'b0;
   logic [11:0]   paddr_in = 12'h000;
   logic [31:0]   pwdata_in = 32'h0;
   logic [131:0]  levels = {11{12'h3c3}};
   wire  [31:0]   prdata_out;
   wire           pready_out;
   wire           pslverr_out;
   wire           comparator_in;
   wire  [11:0]   dac_code_out;
   wire  [3:0]    input_channel_select_out;
   wire           analog_enable_out;
   wire           irq_out;
   logic [31:0]   rd;
   logic          er;
   int            n_fail = 0;
   int            cmp_count = 0;
   int            cycles = 0;
   int            i;
   int            n;
   logic [1:0]    sel;
   logic [3:0]    ch;
   logic [11:0]   lvl;
   logic [7:0]    md;
   // Divider, channel, level, mode expected after completion; slowest divider included
   logic [25:0]   rows [6] = '{{2'd0, 4'h0, 12'h000, 8'h40}, {2'd1, 4'h1, 12'hfff, 8'h51},
                               {2'd2, 4'h5, 12'h800, 8'h65}, {2'd3, 4'ha, 12'h7ff, 8'h7a},
                               {2'd0, 4'ha, 12'h5a3, 8'h4a}, {2'd1, 4'h3, 12'ha5c, 8'h53}};
   sadc_control uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .comparator_in(comparator_in), .dac_code_out(dac_code_out),
      .input_channel_select_out(input_channel_select_out),
      .analog_enable_out(analog_enable_out), .irq_out(irq_out));
   sadc_fe_model fe (.clk_in(clk_in), .dac_code_in(dac_code_out),
      .chan_in(input_channel_select_out), .enable_in(analog_enable_out),
      .levels_in(levels), .comparator_out(comparator_in));
   // ==========
   // Tasks
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      begin
         @(posedge clk_in);
         psel_in <= 1'b1;
         pwrite_in <= w;
         paddr_in <= a;
         pwdata_in <= d;
         @(posedge clk_in);
         penable_in <= 1'b1;
         @(posedge clk_in);
         while (pready_out !== 1'b1) @(posedge clk_in);
         rd = prdata_out;
         er = pslverr_out;
         psel_in <= 1'b0;
         penable_in <= 1'b0;
      end
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      begin
         cmp_count++;
         if (g !== e) begin
            n_fail++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   task wait_irq;
      begin
         n = 0;
         while (irq_out !== 1'b1 && n < 900) begin
            @(posedge clk_in);
            n++;
         end
      end
   endtask
   task end_sim;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
         if (n_fail == 0 && cmp_count > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   // ==========
   // Clock, watchdog and sequence
   initial forever #20 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 30000) begin
         n_fail++;
         end_sim;
      end
   end
   initial begin
      repeat (12) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      apb(1'b0, `SADC_MODE_ADDR, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, `SADC_IRQ_MASK_ADDR, 32'h1);
      for (i = 0; i < 6; i++) begin
         {sel, ch, lvl, md} = rows[i];
         levels[ch*12 +: 12] <= lvl;
         apb(1'b1, `SADC_MODE_ADDR, {24'h0, 2'b10, sel, ch});
         wait_irq;
         chk(n >= (57 << sel) && n <= (58 << sel) + (1 << sel) + 14, 1);
         chk(analog_enable_out, 0);
         apb(1'b0, `SADC_MODE_ADDR, 32'h0);
         chk(rd, {24'h0, md});
         apb(1'b0, `SADC_RES_HIGH_ADDR, 32'h0);
         chk(rd, {24'h0, lvl[11:4]});
         apb(1'b0, `SADC_RES_LOW_ADDR, 32'h0);
         chk(rd, {28'h0, lvl[3:0]});
         apb(1'b1, `SADC_IRQ_STAT_ADDR, 32'h1);
      end
      // Start clears the end flag; stop mid-way gives no completion
      apb(1'b1, `SADC_MODE_ADDR, 32'h82);
      apb(1'b0, `SADC_MODE_ADDR, 32'h0);
      chk(rd, 32'h82);
      apb(1'b1, `SADC_MODE_ADDR, 32'h02);
      repeat (80) @(posedge clk_in);
      apb(1'b0, `SADC_IRQ_STAT_ADDR, 32'h0);
      chk(rd, 32'h0);
      // Unavailable channel raises the masked event only
      apb(1'b1, `SADC_MODE_ADDR, 32'h8b);
      apb(1'b0, `SADC_IRQ_STAT_ADDR, 32'h0);
      chk(rd, 32'h2);
      chk(irq_out, 0);
      chk(analog_enable_out, 0);
      apb(1'b1, `SADC_IRQ_MASK_ADDR, 32'h3);
      apb(1'b1, `SADC_MODE_ADDR, 32'h0);
      chk(irq_out, 1);
      apb(1'b1, `SADC_IRQ_STAT_ADDR, 32'h3);
      apb(1'b0, `SADC_IRQ_STAT_ADDR, 32'h0);
      chk(rd, 32'h0);
      chk(irq_out, 0);
      // Result registers ignore writes; unmapped space refuses
      apb(1'b1, `SADC_RES_HIGH_ADDR, 32'hff);
      apb(1'b0, `SADC_RES_HIGH_ADDR, 32'h0);
      chk(rd, 32'ha5);
      apb(1'b0, 12'h100, 32'h0);
      chk(er, 1);
      chk(rd, 32'h0);
      // Second reset in mid-conversion
      apb(1'b1, `SADC_MODE_ADDR, 32'hb4);
      repeat (30) @(posedge clk_in);
      sys_rst_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      apb(1'b0, `SADC_MODE_ADDR, 32'h0);
      chk(rd, 32'h0);
      chk(analog_enable_out, 0);
      apb(1'b1, `SADC_MODE_ADDR, 32'h07);
      apb(1'b0, `SADC_MODE_ADDR, 32'h0);
      chk(rd, 32'h07);
      chk(input_channel_select_out, 32'h7);
      end_sim;
   end
endmodule

// ==== verilog/sadc_clk_div.v ====
// Conversion clock tick generator dividing the system clock by 1, 2, 4 or 8
`timescale 1ns/1ns
module sadc_clk_div (
   // Clock and reset
   input  wire       clk_in,
   input  wire       sys_rst_in,
   // Control
   input  wire       run_in,
   input  wire [1:0] sel_in,
   // Tick
   output wire       tick_out
);
   reg [2:0] cnt_reg;
   wire [2:0] last_w;

   assign last_w = (3'h1 << sel_in) - 3'h1;
   assign tick_out = run_in && (cnt_reg == last_w);

   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cnt_reg <= 3'h0;
      end else if (!run_in || tick_out) begin
         cnt_reg <= 3'h0;
      end else begin
         cnt_reg <= cnt_reg + 3'h1;
      end
   end
endmodule

// ==== verilog/sadc_consts.vh ====
// Register map, field positions, reset values and timing counts of the converter control
`ifndef SADC_CONSTS_VH
`define SADC_CONSTS_VH
// ==========================================================================
// Register offsets (byte addresses, printed offset 05H kept as index)
`define SADC_MODE_IDX       8'h05
`define SADC_MODE_ADDR      12'h014
`define SADC_RES_HIGH_ADDR  12'h020
`define SADC_RES_LOW_ADDR   12'h024
`define SADC_IRQ_STAT_ADDR  12'h028
`define SADC_IRQ_MASK_ADDR  12'h02c
// ==========================================================================
// Mode register fields
`define SADC_START_BIT      7
`define SADC_EOC_BIT        6
`define SADC_CLK_HI         5
`define SADC_CLK_LO         4
`define SADC_CH_HI          3
`define SADC_CH_LO          0
`define SADC_MODE_RESET     8'h00
`define SADC_CH_LAST        4'ha
// ==========================================================================
// Conversion values and timing
`define SADC_MID_SCALE      12'h800
`define SADC_SETUP_CLKS     4'ha
`define SADC_BIT_CLKS       2'h3
`define SADC_RESULT_BITS    12
`define SADC_RES_HIGH_LSB   4
// ==========================================================================
// Interrupt status bits
`define SADC_IRQ_DONE_BIT   0
`define SADC_IRQ_BAD_BIT    1
`endif

// ==== verilog/sadc_control.v ====
// Converter control top: APB registers, pin sync, divider and SAR sequencer
//
// How it works
// - Conversion starts from mid-scale 800H, refining one bit per step.
// - One channel per conversion, twelve-bit result.
// - Channel field bits 3:0 selects inputs 0 to 10; other codes invalid.
// - Writing start bit 7 begins conversion and clears end flag; zero stops.
// - On completion set end flag bit 6, load result, go idle.
// - Clock field bits 5:4 divides system clock by 1, 2, 4 or 8.
// - Ten set-up clocks then four clocks per bit, 58 in all.
// - Mode register resets to all zeros.
// - Each result overwrites the previous one.
// - Channel field is writable at any time.
// - Mode register readable and writable at offset 05H.
// - First trial compares against half the reference.
`timescale 1ns/1ns
`include "sadc_consts.vh"
module sadc_control (
   // Clock and reset
   input  wire        clk_in,
   input  wire        sys_rst_in,
   // APB slave
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [11:0] paddr_in,
   input  wire [31:0] pwdata_in,
   output wire [31:0] prdata_out,
   output wire        pready_out,
   output wire        pslverr_out,
   // Analog front end
   input  wire        comparator_in,
   output reg  [11:0] dac_code_out,
   output reg  [3:0]  input_channel_select_out,
   output reg         analog_enable_out,
   // Interrupt
   output wire        irq_out
);
   // ======================================================================
   // Registers
   reg        start_reg;
   reg        eoc_reg;
   reg  [1:0] clk_sel_reg;
   reg  [3:0] chan_reg;
   reg  [1:0] irq_stat_reg;
   reg  [1:0] irq_mask_reg;
   reg  [31:0] rdata_reg;
   reg        cmp_meta_reg;
   reg        cmp_sync_reg;
   reg        start_pulse_reg;
   wire       wr_w;
   wire       rd_w;
   wire       mapped_w;
   wire       tick_w;
   wire       busy_w;
   wire       done_w;
   wire [11:0] trial_w;
   wire [11:0] result_w;
   wire [7:0] mode_w;
   wire [1:0] ev_w;

   // ======================================================================
   // APB decode; always ready, error on unmapped address
   function is_mapped;
      input [11:0] a;
      begin
         is_mapped = (a == `SADC_MODE_ADDR) || (a == `SADC_RES_HIGH_ADDR) ||
                     (a == `SADC_RES_LOW_ADDR) || (a == `SADC_IRQ_STAT_ADDR) ||
                     (a == `SADC_IRQ_MASK_ADDR);
      end
   endfunction

   assign mapped_w    = is_mapped(paddr_in);
   assign wr_w        = psel_in && penable_in && pwrite_in && mapped_w;
   assign rd_w        = psel_in && !penable_in && !pwrite_in;
   assign pready_out  = 1'b1;
   assign pslverr_out = psel_in && penable_in && !mapped_w;
   assign prdata_out  = rdata_reg;
   assign mode_w = {start_reg, eoc_reg, clk_sel_reg, chan_reg};
   assign irq_out = |(irq_stat_reg & irq_mask_reg);
   // Events: done, and a start with an unavailable channel code
   assign ev_w = {start_pulse_reg && (chan_reg > `SADC_CH_LAST), done_w};

   // ======================================================================
   // Comparator synchroniser
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cmp_meta_reg <= 1'b0;
         cmp_sync_reg <= 1'b0;
      end else begin
         cmp_meta_reg <= comparator_in;
         cmp_sync_reg <= cmp_meta_reg;
      end
   end

   // ======================================================================
   // Mode register and interrupts
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         start_reg       <= 1'b0;
         eoc_reg         <= 1'b0;
         clk_sel_reg     <= 2'h0;
         chan_reg        <= 4'h0;
         irq_stat_reg    <= 2'h0;
         irq_mask_reg    <= 2'h0;
         start_pulse_reg <= 1'b0;
      end else begin
         start_pulse_reg <= 1'b0;
         if (wr_w && paddr_in == `SADC_MODE_ADDR) begin
            chan_reg    <= pwdata_in[`SADC_CH_HI:`SADC_CH_LO];
            clk_sel_reg <= pwdata_in[`SADC_CLK_HI:`SADC_CLK_LO];
            start_reg   <= pwdata_in[`SADC_START_BIT];
            if (pwdata_in[`SADC_START_BIT]) begin
               eoc_reg         <= 1'b0;
               start_pulse_reg <= 1'b1;
            end else begin
               eoc_reg <= pwdata_in[`SADC_EOC_BIT];
            end
         end
         // Completion wins over a same-cycle clear
         if (done_w) begin
            eoc_reg   <= 1'b1;
            start_reg <= 1'b0;
         end
         if (wr_w && paddr_in == `SADC_IRQ_MASK_ADDR) begin
            irq_mask_reg <= pwdata_in[1:0];
         end
         if (wr_w && paddr_in == `SADC_IRQ_STAT_ADDR) begin
            irq_stat_reg <= (irq_stat_reg & ~pwdata_in[1:0]) | ev_w;
         end else begin
            irq_stat_reg <= irq_stat_reg | ev_w;
         end
      end
   end

   // ======================================================================
   // Read data captured in the setup phase
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata_reg <= 32'h0;
      end else if (rd_w) begin
         case (paddr_in)
            `SADC_MODE_ADDR:     rdata_reg <= {24'h0, mode_w};
            `SADC_RES_HIGH_ADDR: rdata_reg <= {24'h0, result_w[11:`SADC_RES_HIGH_LSB]};
            `SADC_RES_LOW_ADDR:  rdata_reg <= {28'h0, result_w[`SADC_RES_HIGH_LSB-1:0]};
            `SADC_IRQ_STAT_ADDR: rdata_reg <= {30'h0, irq_stat_reg};
            `SADC_IRQ_MASK_ADDR: rdata_reg <= {30'h0, irq_mask_reg};
            default:             rdata_reg <= 32'h0;
         endcase
      end
   end

   // ======================================================================
   // Analog front-end drive
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         dac_code_out             <= 12'h000;
         input_channel_select_out <= 4'h0;
         analog_enable_out        <= 1'b0;
      end else begin
         dac_code_out             <= trial_w;
         input_channel_select_out <= chan_reg;
         // Unavailable codes leave every input disconnected
         analog_enable_out        <= busy_w && (chan_reg <= `SADC_CH_LAST);
      end
   end

   // ======================================================================
   // Submodules
   sadc_clk_div u_div (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .run_in     (busy_w),
      .sel_in     (clk_sel_reg),
      .tick_out   (tick_w)
   );

   sadc_sar u_sar (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .start_in   (start_pulse_reg),
      .abort_in   (!start_reg && busy_w),
      .tick_in    (tick_w),
      .cmp_in     (cmp_sync_reg),
      .busy_out   (busy_w),
      .done_out   (done_w),
      .trial_out  (trial_w),
      .result_out (result_w)
   );
endmodule

// ==== verilog/sadc_sar.v ====
// Successive-approximation sequencer: set-up phase, then four clocks per result bit
`timescale 1ns/1ns
`include "sadc_consts.vh"
module sadc_sar (
   // Clock and reset
   input  wire        clk_in,
   input  wire        sys_rst_in,
   // Control
   input  wire        start_in,
   input  wire        abort_in,
   input  wire        tick_in,
   input  wire        cmp_in,
   // Status and data
   output reg         busy_out,
   output reg         done_out,
   output reg  [11:0] trial_out,
   output reg  [11:0] result_out
);
   // ======================================================================
   // Sequencer state
   localparam ST_IDLE  = 2'h0;
   localparam ST_SETUP = 2'h1;
   localparam ST_BITS  = 2'h2;

   reg [1:0]  state_reg;
   reg [3:0]  setup_reg;
   reg [1:0]  phase_reg;
   reg [3:0]  bit_reg;
   reg [11:0] mask_w;

   always @* begin
      mask_w = 12'h001 << bit_reg;
   end

   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_reg  <= ST_IDLE;
         setup_reg  <= 4'h0;
         phase_reg  <= 2'h0;
         bit_reg    <= 4'h0;
         busy_out   <= 1'b0;
         done_out   <= 1'b0;
         trial_out  <= 12'h000;
         result_out <= 12'h000;
      end else begin
         done_out <= 1'b0;
         if (abort_in) begin
            state_reg <= ST_IDLE;
            busy_out  <= 1'b0;
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  if (start_in) begin
                     trial_out <= `SADC_MID_SCALE;
                     setup_reg <= 4'h0;
                     phase_reg <= 2'h0;
                     bit_reg   <= 4'hb;
                     busy_out  <= 1'b1;
                     state_reg <= ST_SETUP;
                  end
               end
               ST_SETUP: begin
                  if (tick_in) begin
                     setup_reg <= setup_reg + 4'h1;
                     if (setup_reg == `SADC_SETUP_CLKS - 4'h1) begin
                        state_reg <= ST_BITS;
                     end
                  end
               end
               ST_BITS: begin
                  if (tick_in) begin
                     phase_reg <= phase_reg + 2'h1;
                     if (phase_reg == `SADC_BIT_CLKS) begin
                        // Decide this bit on the last of its four clocks
                        if (!cmp_in) begin
                           trial_out <= (trial_out & ~mask_w) | (mask_w >> 1);
                        end else begin
                           trial_out <= trial_out | (mask_w >> 1);
                        end
                        if (bit_reg == 4'h0) begin
                           result_out <= cmp_in ? trial_out : (trial_out & ~mask_w);
                           done_out   <= 1'b1;
                           busy_out   <= 1'b0;
                           state_reg  <= ST_IDLE;
                        end else begin
                           bit_reg <= bit_reg - 4'h1;
                        end
                     end
                  end
               end
               default: begin
                  state_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule
